// File: logic/gfc_pkg.sv
// shared constants for the gpio and function configuration register bank
package gfc_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] REG_IDX_GPIO   = 8'h0B;
    localparam logic [7:0] REG_IDX_CFG3   = 8'h0C;

    // general_io_control field positions
    localparam int         AMP_LSB        = 5;
    localparam int         AMP_W          = 3;
    localparam int         GPIO_DIR_LSB   = 2;
    localparam int         GPIO_DATA_LSB  = 0;
    localparam int         GPIO_PINS      = 2;

    // function_config_three field positions
    localparam int         AC_LEADOFF_MODE_SELECT_BIT    = 7;
    localparam int         HALF_REF_BIT   = 6;
    localparam int         IN_CRC_BIT     = 3;
    localparam int         OUT_CRC_BIT    = 2;
    localparam int         TMO_LSB        = 0;
    localparam int         TMO_W          = 2;

    // values after reset
    localparam logic [1:0] GPIO_DIR_RST   = 2'h3;
    localparam logic [1:0] GPIO_DATA_RST  = 2'h0;
    localparam logic [2:0] AMP_RST        = 3'h0;
    localparam logic [1:0] TMO_RST        = 2'h0;
    localparam logic       AC_LEADOFF_MODE_SELECT_RST    = 1'b0;
    localparam logic       HALF_REF_RST   = 1'b0;
    localparam logic       IN_CRC_RST     = 1'b0;
    localparam logic       OUT_CRC_RST    = 1'b0;

    // amplitude division codes
    localparam logic [2:0] AMP_DIV8       = 3'h3;
    localparam logic [2:0] AMP_DIV16      = 3'h4;

    // idle timeout codes and their limits in divided clock cycles
    localparam logic [1:0] TMO_OFF        = 2'h0;
    localparam logic [1:0] TMO_SHORT      = 2'h1;
    localparam logic [1:0] TMO_MID        = 2'h2;
    localparam int         TMO_CNT_W      = 12;
    localparam logic [11:0] TMO_LIM_SHORT = 12'h0FF;
    localparam logic [11:0] TMO_LIM_MID   = 12'h3FF;
    localparam logic [11:0] TMO_LIM_LONG  = 12'hFFF;

    // idle timer states
    typedef enum logic [1:0] {TMR_OFF, TMR_COUNT, TMR_EXPIRED} gfc_tmr_state_t;

endpackage

// File: logic/gfc_gpio_port.sv
// output latch and pad control of the general-purpose pins
`timescale 1ns/1ps
module gfc_gpio_port #(
    parameter int PINS = 2
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            wr_en,
    input  wire logic [PINS-1:0] wr_data,
    input  wire logic [PINS-1:0] dir,
    input  wire logic            blocked,
    output logic      [PINS-1:0] pin_o,
    output logic      [PINS-1:0] pin_oe
);
    import gfc_pkg::*;

    logic [PINS-1:0] out_q;
    logic [PINS-1:0] out_d;

    // the register field layout only has room for two pins
    if (PINS != GPIO_PINS)
    begin : g_check
        $error("gfc_gpio_port: PINS must be 2");
    end

    // per pin: only an output pin takes the written level
    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
        always_comb
        begin
            out_d[i] = out_q[i];
            if (wr_en && !dir[i])
                out_d[i] = wr_data[i];
        end
        // respiration modes take the pins away whatever the settings say
        assign pin_oe[i] = !dir[i] && !blocked;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_q <= GPIO_DATA_RST;
        else
            out_q <= out_d;
    end

    assign pin_o = out_q;

endmodule // gfc_gpio_port

// File: logic/gfc_idle_timer.sv
// idle timeout that resets the serial interface
`timescale 1ns/1ps
module gfc_idle_timer #(
    parameter int CNT_W = 12
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] code,
    input  wire logic       idle,
    input  wire logic       activity,
    input  wire logic       tick,
    output logic            expire
);
    import gfc_pkg::*;

    gfc_tmr_state_t   state_q;
    gfc_tmr_state_t   state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic             expire_q;
    logic             expire_d;

    if (CNT_W < TMO_CNT_W)
    begin : g_check
        $error("gfc_idle_timer: CNT_W must hold 4095");
    end

    // limit in divided clock cycles
    always_comb
    begin
        case (code)
            TMO_SHORT: limit = CNT_W'(TMO_LIM_SHORT);
            TMO_MID:   limit = CNT_W'(TMO_LIM_MID);
            default:   limit = CNT_W'(TMO_LIM_LONG);
        endcase
    end

    // after expiry it waits for new activity so it fires once per idle spell
    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        expire_d = 1'b0;
        if (code == TMO_OFF)
        begin
            state_d = TMR_OFF;
            cnt_d   = '0;
        end
        else if (activity || !idle)
        begin
            state_d = TMR_COUNT;
            cnt_d   = '0;
        end
        else
        begin
            case (state_q)
                TMR_OFF:
                begin
                    state_d = TMR_COUNT;
                    cnt_d   = '0;
                end
                TMR_COUNT:
                begin
                    if (tick)
                    begin
                        cnt_d = cnt_q + CNT_W'(1);
                        if (cnt_d >= limit)
                        begin
                            expire_d = 1'b1;
                            state_d  = TMR_EXPIRED;
                            cnt_d    = '0;
                        end
                    end
                end
                TMR_EXPIRED: cnt_d = '0;
                default:     state_d = TMR_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q  <= TMR_OFF;
            cnt_q    <= '0;
            expire_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            expire_q <= expire_d;
        end
    end

    assign expire = expire_q;

endmodule // gfc_idle_timer

// File: logic/gfc_top.sv
// apb register bank for gpio control and function configuration three
//
// Operation
// - each gpio_direction bit makes its pin an output at 0 and an input at 1, both 1 after reset.
// - reading gpio_pin_data returns the live level of each pin whatever its direction.
// - writing gpio_pin_data sets the driven level of a pin that is an output.
// - writing gpio_pin_data for an input pin changes neither the pin nor later reads.
// - the top three bits of general_io_control pick amplitude division, 011 one eighth, 100 one sixteenth.
// - in certain respiration modes the gpio pins are unavailable whatever the settings.
// - ac_leadoff_mode_select picks software lead-off at 0, after reset, and hardware at 1.
// - half_ref_switch_on closes the half-reference switch at 1, open after reset.
// - input_crc_enable turns on crc checking of host data at 1, off after reset.
// - output_crc_enable turns on crc protection of device data at 1, off after reset.
// - the idle timeout code disables at 00 and picks 255, 1023 or 4095 divided clock cycles.
`timescale 1ns/1ps
module gfc_top #(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 12
) (
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    // general-purpose pins
    input  wire logic [gfc_pkg::GPIO_PINS-1:0] gpio_pin_i,
    output logic      [gfc_pkg::GPIO_PINS-1:0] gpio_pin_o,
    output logic      [gfc_pkg::GPIO_PINS-1:0] gpio_pin_oe,
    input  wire logic              resp_gpio_block,
    // serial interface supervision
    input  wire logic              serial_idle,
    input  wire logic              serial_activity,
    input  wire logic              timeout_tick,
    output logic                   serial_if_reset,
    // configuration outputs to the analog and serial logic
    output logic                   ac_leadoff_mode_select,
    output logic                   half_ref_switch_on,
    output logic                   input_crc_enable,
    output logic                   output_crc_enable,
    output logic      [2:0]        amp_div_code,
    output logic                   amp_div_eighth,
    output logic                   amp_div_sixteenth
);
    import gfc_pkg::*;

    // bus timing, zero wait states throughout
    //   setup cycle: read byte and pin levels captured into prdata_q
    //   access cycle: pready high, pslverr high for an unmapped word
    //   closing edge: a write lands; outputs show it straight after that edge
    // only byte lane 0 carries register bits; the upper lanes are ignored
    // after reset both directions read 1, so no pin is driven
    // resp_gpio_block wins over any direction or data setting
    // an idle timeout never touches the register contents
    // the timer sees a new code straight after its write edge
    // reserved bits are dropped on write and read back as zero
    // limitation: pins are read in the setup cycle, one cycle early
    // trade-off: pready is tied high, so no access can be stretched

    // word address match; the two low address bits are ignored
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        idx);
        reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // indices of 0x0C need at least eight address bits
    if (ADDR_W < 8)
    begin : g_check
        $error("gfc_top: ADDR_W must be at least 8");
    end

    // the longest timeout needs a twelve-bit count
    if (CNT_W < TMO_CNT_W)
    begin : g_cnt_check
        $error("gfc_top: CNT_W must be at least 12");
    end

    // bus phase decode
    logic setup_ph;
    logic access_ph;

    // register selects
    logic hit_gpio;
    logic hit_cfg3;
    logic mapped;

    // write strobes per register
    logic wr_fire;
    logic wr_gpio;
    logic wr_cfg3;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_gpio  = reg_hit(paddr, REG_IDX_GPIO);
    assign hit_cfg3  = reg_hit(paddr, REG_IDX_CFG3);
    assign mapped    = hit_gpio || hit_cfg3;

    // writes land on the access edge; only byte lane 0 carries register bits
    assign wr_fire = access_ph && pwrite && pstrb[0];
    assign wr_gpio = wr_fire && hit_gpio;
    assign wr_cfg3 = wr_fire && hit_cfg3;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;

    // an unmapped word is refused and a write to it changes nothing
    assign pslverr = access_ph && !mapped;

    // general_io_control state
    logic [AMP_W-1:0]     amp_q;
    logic [AMP_W-1:0]     amp_d;

    // pin directions, 1 makes a pin an input
    logic [GPIO_PINS-1:0] dir_q;
    logic [GPIO_PINS-1:0] dir_d;

    // amplitude and direction fields
    always_comb
    begin
        amp_d = amp_q;
        dir_d = dir_q;
        if (wr_gpio)
        begin
            amp_d = pwdata[AMP_LSB +: AMP_W];
            dir_d = pwdata[GPIO_DIR_LSB +: GPIO_PINS];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            amp_q <= AMP_RST;
            dir_q <= GPIO_DIR_RST;
        end
        else
        begin
            amp_q <= amp_d;
            dir_q <= dir_d;
        end
    end

    // pin output latch and pad enables live in their own module
    gfc_gpio_port #(
        .PINS    (GPIO_PINS)
    ) u_gpio (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_gpio),
        .wr_data (pwdata[GPIO_DATA_LSB +: GPIO_PINS]),
        .dir     (dir_q),
        .blocked (resp_gpio_block),
        .pin_o   (gpio_pin_o),
        .pin_oe  (gpio_pin_oe)
    );

    // function_config_three state
    logic             ac_leadoff_mode_select_q;
    logic             ac_leadoff_mode_select_d;
    logic             half_ref_q;
    logic             half_ref_d;

    // crc enables for both directions of the serial link
    logic             in_crc_q;
    logic             in_crc_d;
    logic             out_crc_q;
    logic             out_crc_d;

    // idle timeout code
    logic [TMO_W-1:0] tmo_q;
    logic [TMO_W-1:0] tmo_d;

    // reserved bits 5 and 4 are not stored and read back as zero
    always_comb
    begin
        ac_leadoff_mode_select_d  = ac_leadoff_mode_select_q;
        half_ref_d = half_ref_q;
        in_crc_d   = in_crc_q;
        out_crc_d  = out_crc_q;
        tmo_d      = tmo_q;
        if (wr_cfg3)
        begin
            ac_leadoff_mode_select_d  = pwdata[AC_LEADOFF_MODE_SELECT_BIT];
            half_ref_d = pwdata[HALF_REF_BIT];
            in_crc_d   = pwdata[IN_CRC_BIT];
            out_crc_d  = pwdata[OUT_CRC_BIT];
            tmo_d      = pwdata[TMO_LSB +: TMO_W];
        end
    end

    // timeout expiry does not touch these, so contents survive it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ac_leadoff_mode_select_q  <= AC_LEADOFF_MODE_SELECT_RST;
            half_ref_q <= HALF_REF_RST;
            in_crc_q   <= IN_CRC_RST;
            out_crc_q  <= OUT_CRC_RST;
            tmo_q      <= TMO_RST;
        end
        else
        begin
            ac_leadoff_mode_select_q  <= ac_leadoff_mode_select_d;
            half_ref_q <= half_ref_d;
            in_crc_q   <= in_crc_d;
            out_crc_q  <= out_crc_d;
            tmo_q      <= tmo_d;
        end
    end

    // idle supervision of the serial interface
    // its expiry pulse goes straight out to the serial block
    gfc_idle_timer #(
        .CNT_W    (CNT_W)
    ) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .code     (tmo_q),
        .idle     (serial_idle),
        .activity (serial_activity),
        .tick     (timeout_tick),
        .expire   (serial_if_reset)
    );

    // readable byte of each register; reserved bits read as zero
    logic [7:0]  gpio_rd_byte;
    logic [7:0]  cfg3_rd_byte;

    // general_io_control as the host sees it, pins at their live level
    always_comb
    begin
        gpio_rd_byte                             = 8'h00;
        gpio_rd_byte[AMP_LSB +: AMP_W]           = amp_q;
        gpio_rd_byte[GPIO_DIR_LSB +: GPIO_PINS]  = dir_q;
        gpio_rd_byte[GPIO_DATA_LSB +: GPIO_PINS] = gpio_pin_i;
    end

    // function_config_three as the host sees it; bits 5 and 4 are not stored
    always_comb
    begin
        cfg3_rd_byte                   = 8'h00;
        cfg3_rd_byte[AC_LEADOFF_MODE_SELECT_BIT]      = ac_leadoff_mode_select_q;
        cfg3_rd_byte[HALF_REF_BIT]     = half_ref_q;
        cfg3_rd_byte[IN_CRC_BIT]       = in_crc_q;
        cfg3_rd_byte[OUT_CRC_BIT]      = out_crc_q;
        cfg3_rd_byte[TMO_LSB +: TMO_W] = tmo_q;
    end

    // read data, captured in the setup cycle so prdata comes from a flop
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // pins are sampled one cycle before the data is taken by the master
    always_comb
    begin
        prdata_d = prdata_q;
        if (setup_ph && !pwrite)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_gpio)
                prdata_d[7:0] = gpio_rd_byte;
            else if (hit_cfg3)
                prdata_d[7:0] = cfg3_rd_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else
            prdata_q <= prdata_d;
    end

    // prdata holds until the next read setup cycle
    assign prdata = prdata_q;

    // configuration outputs straight from their flops
    assign ac_leadoff_mode_select = ac_leadoff_mode_select_q;
    assign half_ref_switch_on     = half_ref_q;

    // crc enables and amplitude code for the serial and analog logic
    assign input_crc_enable       = in_crc_q;
    assign output_crc_enable      = out_crc_q;
    assign amp_div_code           = amp_q;

    // reserved amplitude codes select no division at all
    assign amp_div_eighth    = (amp_q == AMP_DIV8);
    assign amp_div_sixteenth = (amp_q == AMP_DIV16);

endmodule // gfc_top

// File: testbench/gfc_monitor.sv
// port checker for the gpio and function configuration bank
`timescale 1ns/1ps
module gfc_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [ADDR_W-1:0]             paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [3:0]                    pstrb,
    input wire logic                          pready,
    input wire logic [31:0]                   prdata,
    input wire logic                          pslverr,
    input wire logic [gfc_pkg::GPIO_PINS-1:0] gpio_pin_o,
    input wire logic [gfc_pkg::GPIO_PINS-1:0] gpio_pin_oe,
    input wire logic                          resp_gpio_block,
    input wire logic                          serial_activity,
    input wire logic                          serial_if_reset,
    input wire logic                          ac_leadoff_mode_select,
    input wire logic                          half_ref_switch_on,
    input wire logic                          input_crc_enable,
    input wire logic                          output_crc_enable,
    input wire logic [2:0]                    amp_div_code,
    input wire logic                          amp_div_eighth,
    input wire logic                          amp_div_sixteenth
);
    import gfc_pkg::*;
    // decode of committed writes; only the low strobe lane carries data
    logic wr_gp;
    logic wr_cf;
    logic mapped;
    assign mapped = paddr[7:2] == REG_IDX_GPIO[5:0] || paddr[7:2] == REG_IDX_CFG3[5:0];
    assign wr_gp  = psel && penable && pwrite && pstrb[0] && paddr[7:2] == REG_IDX_GPIO[5:0];
    assign wr_cf  = psel && penable && pwrite && pstrb[0] && paddr[7:2] == REG_IDX_CFG3[5:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    zero_wait_a: assert property (psel && penable |-> pready) else $error("no ready in access");
    bad_addr_a: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    ac_leadoff_mode_select_wr_a: assert property (wr_cf |=> ac_leadoff_mode_select == $past(pwdata[7]))
        else $error("lead-off mode not written");
    half_ref_wr_a: assert property (wr_cf |=> half_ref_switch_on == $past(pwdata[6]))
        else $error("half ref switch not written");
    crc_wr_a: assert property (wr_cf |=> {input_crc_enable, output_crc_enable} == $past(pwdata[3:2]))
        else $error("crc enables not written");
    amp_wr_a: assert property (wr_gp |=> amp_div_code == $past(pwdata[7:5]))
        else $error("amplitude code not written");
    amp_decode_a: assert property (amp_div_eighth == (amp_div_code == AMP_DIV8) && amp_div_sixteenth == (amp_div_code == AMP_DIV16))
        else $error("amplitude decode wrong");
    pin_block_a: assert property (resp_gpio_block |-> gpio_pin_oe == 2'h0)
        else $error("pin driven while blocked");
    out_latch_a: assert property (wr_gp && !resp_gpio_block && gpio_pin_oe[0] |=> gpio_pin_o[0] == $past(pwdata[0]))
        else $error("output pin level not written");
    in_drop_a: assert property (wr_gp && !resp_gpio_block && !gpio_pin_oe[0] |=> $stable(gpio_pin_o[0]))
        else $error("input pin latch changed");
    activity_hold_a: assert property (serial_activity [*3] |-> ##1 !serial_if_reset)
        else $error("timeout during activity");
    pulse_one_a: assert property (serial_if_reset |=> !serial_if_reset)
        else $error("reset pulse too long");
endmodule // gfc_monitor

// File: testbench/gfc_far_end.sv
// host side model: pin pads and serial interface activity
`timescale 1ns/1ps
module gfc_far_end (
    input  wire logic [gfc_pkg::GPIO_PINS-1:0] pin_o,
    input  wire logic [gfc_pkg::GPIO_PINS-1:0] pin_oe,
    input  wire logic [gfc_pkg::GPIO_PINS-1:0] ext_lvl,
    input  wire logic                          frame,
    output logic      [gfc_pkg::GPIO_PINS-1:0] pin_i,
    output logic                               serial_idle,
    output logic                               serial_activity
);
    import gfc_pkg::*;
    // host drives a pad only where the device has let go of it
    always_comb
    begin
        for (int i = 0; i < GPIO_PINS; i++)
            pin_i[i] = pin_oe[i] ? pin_o[i] : ext_lvl[i];
    end
    // a frame keeps the interface busy with clock edges throughout
    assign serial_idle     = !frame;
    assign serial_activity = frame;
endmodule // gfc_far_end

// File: testbench/tb.sv
// self-checking bench for the gpio and function configuration bank
`timescale 1ns/1ps
module tb;
    import gfc_pkg::*;
    localparam logic [7:0] A_GP = 8'h2C;
    localparam logic [7:0] A_CF = 8'h30;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, rerr;
    logic [31:0] prdata, rdat;
    logic [1:0]  pin_i, pin_o, pin_oe;
    logic [1:0]  ext_lvl = 2'h2;
    logic        frame = 1'b0;
    logic        blk = 1'b0;
    logic        tick = 1'b0;
    logic        idle, act, sreset, ac, half, inc, outc, e8, e16;
    logic [2:0]  amp;
    int          fails = 0;
    int          checked = 0;
    int          pulses = 0;
    logic [7:0]  cv [5] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'hCC};

    always #20 pclk = ~pclk;
    // count expiry pulses as the serial block would see them
    always @(posedge pclk)
        if (sreset === 1'b1) pulses++;

    gfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .gpio_pin_i(pin_i), .gpio_pin_o(pin_o),
        .gpio_pin_oe(pin_oe), .resp_gpio_block(blk), .serial_idle(idle),
        .serial_activity(act), .timeout_tick(tick), .serial_if_reset(sreset),
        .ac_leadoff_mode_select(ac), .half_ref_switch_on(half), .input_crc_enable(inc),
        .output_crc_enable(outc), .amp_div_code(amp), .amp_div_eighth(e8),
        .amp_div_sixteenth(e16));
    gfc_far_end u_host (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .frame(frame),
        .pin_i(pin_i), .serial_idle(idle), .serial_activity(act));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the slave sets the length of the access phase
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            fails++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hF);
        @(negedge pclk);   // written value settles after its edge
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, 4'hF);
        chk({rerr, rdat}, {9'h0, e});
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            tick <= 1'b1;
            @(posedge pclk);
            tick <= 1'b0;
        end
    endtask

    // three busy cycles restart the idle count
    task automatic burst;
        @(posedge pclk);
        frame <= 1'b1;
        repeat (3) @(posedge pclk);
        frame <= 1'b0;
    endtask

    // nonzero codes pulse only on the last tick of the window, none before it; code 0 never pulses
    task automatic run_tmo(input logic [1:0] c, input int n);
        int p;
        p = pulses;
        wr(A_CF, {6'h0, c});
        burst();
        ticks(100);
        burst();
        ticks(n - 1);
        repeat (3) @(posedge pclk);
        chk(pulses, p);
        ticks(1);
        repeat (3) @(posedge pclk);
        chk(pulses, p + int'(c != 2'h0));
        rd(A_CF, {6'h0, c});
        $display("timeout code %0d done", c);
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({pin_oe, pin_o, ac, half, inc, outc, amp, sreset}, 32'h0);
        rd(A_GP, 8'h0E);
        rd(A_CF, 8'h00);
        foreach (cv[i])
        begin
            wr(A_CF, cv[i]);
            rd(A_CF, cv[i]);
            chk({ac, half, inc, outc}, {cv[i][7:6], cv[i][3:2]});
        end
        apb(1'b1, A_CF, 8'h00, 4'hE);
        rd(A_CF, 8'hCC);
        apb(1'b1, 8'h34, 8'hFF, 4'hF);
        chk(rerr, 1'b1);
        rd(A_CF, 8'hCC);
        apb(1'b0, 8'h34, 8'h00, 4'hF);
        chk({rerr, rdat}, {1'b1, 32'h0});
        $display("config register done");
        for (int c = 0; c < 8; c++)
        begin
            wr(A_GP, {c[2:0], 5'h0C});
            chk({amp, e8, e16}, {c[2:0], c == 3, c == 4});
            rd(A_GP, {c[2:0], 5'h0E});
        end
        $display("amplitude codes done");
        wr(A_GP, 8'h0F);
        chk({pin_oe, pin_o}, 4'h0);
        rd(A_GP, 8'h0E);
        wr(A_GP, 8'h0B);
        chk({pin_oe, pin_o}, 4'h4);
        rd(A_GP, 8'h0A);
        wr(A_GP, 8'h09);
        chk({pin_oe, pin_o}, 4'h5);
        rd(A_GP, 8'h0B);
        ext_lvl <= 2'h0;
        rd(A_GP, 8'h09);
        blk <= 1'b1;
        @(posedge pclk);
        chk(pin_oe, 2'h0);
        rd(A_GP, 8'h08);
        blk <= 1'b0;
        wr(A_GP, 8'h0D);
        chk({pin_oe, pin_o}, 4'h1);
        $display("gpio done");
        run_tmo(2'h0, 300);
        run_tmo(2'h1, 255);
        run_tmo(2'h2, 1023);
        run_tmo(2'h3, 4095);
        report_and_stop();
    end
endmodule // tb

bind gfc_top gfc_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gpio_pin_o(gpio_pin_o), .gpio_pin_oe(gpio_pin_oe), .resp_gpio_block(resp_gpio_block),
    .serial_activity(serial_activity), .serial_if_reset(serial_if_reset),
    .ac_leadoff_mode_select(ac_leadoff_mode_select), .half_ref_switch_on(half_ref_switch_on),
    .input_crc_enable(input_crc_enable), .output_crc_enable(output_crc_enable),
    .amp_div_code(amp_div_code), .amp_div_eighth(amp_div_eighth),
    .amp_div_sixteenth(amp_div_sixteenth));
